//--- verilog/spi_pkg.sv
package spi_pkg;
    // Register map
    localparam int          ADDR_W     = 8;
    localparam logic [7:0]  ADDR_CTRL  = 8'hF3;
    localparam logic [7:0]  ADDR_STAT  = 8'hF4;
    localparam logic [7:0]  ADDR_DATA  = 8'hF5;
    localparam logic [7:0]  ADDR_AUX   = 8'hA2;
    // Reset values
    localparam logic [7:0]  CTRL_RST   = 8'h00;
    localparam logic [7:0]  STAT_RST   = 8'h00;
    localparam logic [7:0]  AUX_RST    = 8'h00;
    localparam logic [7:0]  DATA_RST   = 8'h00;
    // Control register fields
    localparam int          B_SELOE    = 7;
    localparam int          B_EN       = 6;
    localparam int          B_LSB      = 5;
    localparam int          B_MASTER   = 4;
    localparam int          B_IDLE_LEVEL_SELECT     = 3;
    localparam int          B_SAMPLE_EDGE_SELECT     = 2;
    // Status register fields
    localparam int          B_TCF      = 7;
    localparam int          B_COLL     = 6;
    localparam int          B_OVF      = 5;
    localparam int          B_MFAULT   = 4;
    localparam int          B_FDIS     = 3;
    // Auxiliary register fields
    localparam int          B_PINSEL   = 7;
    // Shift clock timing: divider 16 << rate, half period in system clocks
    localparam int          DIV_MIN    = 16;
    localparam logic [6:0]  HALF_BASE  = 7'(DIV_MIN / 2);
    localparam logic [3:0]  LAST_EDGE  = 4'hF;

    typedef enum logic {ST_IDLE, ST_XFER} st_t;
endpackage : spi_pkg

//--- verilog/serial_peripheral_port.sv
// Functional notes
// - Master shift clock at most system clock/16; slave accepts up to clock/4.
// - Single transmit buffer; no shifter load until current transfer completes.
// - Received byte moves to a read buffer, freeing the shifter.
// - Data-out line driven by master, input for slave; other line opposite.
// - Shift clock pin output in master, input in slave; data moves with it.
// - Exactly eight shift clock cycles per transfer, one master at a time.
// - Slave active only while its select is low; high deactivates it.
// - In master mode select pin is not a select; GPIO or fault input.
// - Transfer swaps master and slave shifter contents like one 16-bit ring.
// - MSB first by default, LSB first when lsb_first_enable set.
// - pin_group_select routes the four signals to pin group 0 or 1.
// - select_output_enable acts only with master_select and fault_detect_disable set.
// - Auto select drives low per byte and high while idle.
// - port_enable_bit 0 disables the whole port, 1 enables it.
// - master_select 0 gives slave mode, 1 gives master mode.
// - Transfer-complete and write-collision flags visible to software.
// - Mode fault detection flags a conflict between masters.
// - idle_level_select sets shift clock idle level low or high.
// - sample_edge_select samples on first edge when 0, second when 1.
// - Rate codes 00,01,10,11 give dividers 16,32,64,128.
// - Master with fault_detect_disable clear uses select pin as fault input.
`timescale 1ns/1ps
module serial_peripheral_port (
    // Clock and reset
    input  wire logic                        ref_clk_i,
    input  wire logic                        srst_i,
    // Register port
    input  wire logic [spi_pkg::ADDR_W-1:0]  addr_i,
    input  wire logic [7:0]                  wdata_i,
    input  wire logic                        wr_i,
    input  wire logic                        rd_i,
    output logic      [7:0]                  rdata_o,
    // Shift clock, one bit per pin group
    input  wire logic [1:0]                  sck_i,
    output logic      [1:0]                  sck_o,
    output logic      [1:0]                  sck_oe_o,
    // Master-out line
    input  wire logic [1:0]                  mosi_i,
    output logic      [1:0]                  mosi_o,
    output logic      [1:0]                  mosi_oe_o,
    // Master-in line
    input  wire logic [1:0]                  miso_i,
    output logic      [1:0]                  miso_o,
    output logic      [1:0]                  miso_oe_o,
    // Slave select, active low on the wire
    input  wire logic [1:0]                  ss_n_i,
    output logic      [1:0]                  ss_n_o,
    output logic      [1:0]                  ss_n_oe_o
);
    import spi_pkg::*;

    function automatic logic out_bit(input logic [7:0] sh, input logic lsb);
        out_bit = lsb ? sh[0] : sh[7];
    endfunction : out_bit

    function automatic logic [7:0] shift_in(input logic [7:0] sh, input logic b,
                                            input logic lsb);
        shift_in = lsb ? {b, sh[7:1]} : {sh[6:0], b};
    endfunction : shift_in

    st_t        st_q,       st_d;
    logic [7:0] ctrl_q,     ctrl_d;
    logic       pinsel_q,   pinsel_d;
    logic       tcf_q,      tcf_d;
    logic       coll_q,     coll_d;
    logic       ovf_q,      ovf_d;
    logic       mfault_q,   mfault_d;
    logic       fdis_q,     fdis_d;
    logic       tail_q,     tail_d;
    logic [7:0] rxbuf_q,    rxbuf_d;
    logic [7:0] sh_q,       sh_d;
    logic       dout_q,     dout_d;
    logic [3:0] cnt_q,      cnt_d;
    logic [6:0] div_q,      div_d;
    logic       sck_lvl_q,  sck_lvl_d;
    logic       sck_prev_q, sck_prev_d;
    logic [7:0] rdata_q,    rdata_d;

    logic       en;
    logic       mst;
    logic       lsb;
    logic       sample_edge_select;
    logic       ss_in;
    logic       sel;
    logic       autosel_act;
    logic [6:0] half;
    logic       mtick;
    logic       stick;
    logic       edge_p;
    logic       samp;
    logic       done;
    logic       fault;

    always_comb begin
        st_d       = st_q;
        ctrl_d     = ctrl_q;
        pinsel_d   = pinsel_q;
        tcf_d      = tcf_q;
        coll_d     = coll_q;
        ovf_d      = ovf_q;
        mfault_d   = mfault_q;
        fdis_d     = fdis_q;
        rxbuf_d    = rxbuf_q;
        sh_d       = sh_q;
        dout_d     = dout_q;
        cnt_d      = cnt_q;
        div_d      = div_q;
        sck_lvl_d  = sck_lvl_q;
        rdata_d    = 8'h00;

        en       = ctrl_q[B_EN];
        mst      = ctrl_q[B_MASTER];
        lsb      = ctrl_q[B_LSB];
        sample_edge_select     = ctrl_q[B_SAMPLE_EDGE_SELECT];
        ss_in    = ss_n_i[pinsel_q];
        sel      = en & ~mst & ~ss_in;
        autosel_act = en & mst & fdis_q & ctrl_q[B_SELOE];
        fault    = en & mst & ~fdis_q & ~ss_in;
        half     = 7'(HALF_BASE << ctrl_q[1:0]);
        mtick    = en & mst & (st_q == ST_XFER) & (div_q == half - 7'h01);
        stick    = sel & (sck_i[pinsel_q] != sck_prev_q);
        edge_p   = mtick | stick;
        samp     = edge_p & (cnt_q[0] == sample_edge_select);
        done     = edge_p & (cnt_q == LAST_EDGE);
        sck_prev_d = sck_i[pinsel_q];
        // Keeps auto select low over the last clock edge on the pins
        tail_d     = done;

        // Register writes; hardware events below take priority
        if (wr_i) begin
            case (addr_i)
                ADDR_CTRL: ctrl_d = wdata_i;
                ADDR_AUX:  pinsel_d = wdata_i[B_PINSEL];
                ADDR_STAT: begin
                    tcf_d     = tcf_q  & wdata_i[B_TCF];
                    coll_d    = coll_q & wdata_i[B_COLL];
                    ovf_d     = ovf_q  & wdata_i[B_OVF];
                    mfault_d  = mfault_q & wdata_i[B_MFAULT];
                    fdis_d    = wdata_i[B_FDIS];
                end
                ADDR_DATA: begin
                    if (st_q == ST_XFER || stick) begin
                        coll_d = 1'b1;
                    end else begin
                        sh_d   = wdata_i;
                        dout_d = out_bit(wdata_i, lsb);
                        if (en && mst) begin
                            st_d  = ST_XFER;
                            div_d = 7'h00;
                        end
                    end
                end
                default: ;
            endcase
        end

        // Master clock divider and shift clock level
        if (st_q == ST_XFER && en && mst) begin
            div_d = mtick ? 7'h00 : div_q + 7'h01;
        end
        if (mtick) begin
            sck_lvl_d = ~sck_lvl_q;
        end
        if (st_q == ST_IDLE) begin
            sck_lvl_d = ctrl_q[B_IDLE_LEVEL_SELECT];
        end

        // Shifting: sample edges take a bit in, the other edges present the next
        if (samp) begin
            sh_d = shift_in(sh_q, mst ? miso_i[pinsel_q] : mosi_i[pinsel_q], lsb);
        end else if (edge_p) begin
            dout_d = out_bit(sh_q, lsb);
        end else if (st_q == ST_IDLE && !(wr_i && addr_i == ADDR_DATA)) begin
            dout_d = out_bit(sh_q, lsb);
        end
        if (edge_p) begin
            cnt_d = cnt_q + 4'h1;
            st_d  = ST_XFER;
        end
        if (done) begin
            st_d  = ST_IDLE;
            cnt_d = 4'h0;
            tcf_d = 1'b1;
            if (tcf_q) begin
                ovf_d = 1'b1;
            end else begin
                rxbuf_d = sh_d;
            end
        end

        // Deselect, disable and mode fault abort the transfer
        if (!en || (!mst && ss_in)) begin
            if (!mst || !en) begin
                st_d  = ST_IDLE;
                cnt_d = 4'h0;
            end
        end
        if (fault) begin
            mfault_d         = 1'b1;
            ctrl_d[B_MASTER] = 1'b0;
            st_d           = ST_IDLE;
            cnt_d          = 4'h0;
        end

        if (rd_i) begin
            case (addr_i)
                ADDR_CTRL: rdata_d = ctrl_q;
                ADDR_STAT: rdata_d = {tcf_q, coll_q, ovf_q, mfault_q, fdis_q, 3'b000};
                ADDR_DATA: rdata_d = rxbuf_q;
                ADDR_AUX:  rdata_d = {pinsel_q, 7'h00};
                default:   rdata_d = 8'h00;
            endcase
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            st_q       <= ST_IDLE;
            ctrl_q     <= CTRL_RST;
            pinsel_q   <= AUX_RST[B_PINSEL];
            tcf_q      <= STAT_RST[B_TCF];
            coll_q     <= STAT_RST[B_COLL];
            ovf_q      <= STAT_RST[B_OVF];
            mfault_q   <= STAT_RST[B_MFAULT];
            fdis_q     <= STAT_RST[B_FDIS];
            rxbuf_q    <= DATA_RST;
            sh_q       <= DATA_RST;
            dout_q     <= 1'b0;
            cnt_q      <= 4'h0;
            div_q      <= 7'h00;
            sck_lvl_q  <= CTRL_RST[B_IDLE_LEVEL_SELECT];
            sck_prev_q <= 1'b0;
            tail_q     <= 1'b0;
            rdata_q    <= 8'h00;
        end else begin
            st_q       <= st_d;
            ctrl_q     <= ctrl_d;
            pinsel_q   <= pinsel_d;
            tcf_q      <= tcf_d;
            coll_q     <= coll_d;
            ovf_q      <= ovf_d;
            mfault_q   <= mfault_d;
            fdis_q     <= fdis_d;
            rxbuf_q    <= rxbuf_d;
            sh_q       <= sh_d;
            dout_q     <= dout_d;
            cnt_q      <= cnt_d;
            div_q      <= div_d;
            sck_lvl_q  <= sck_lvl_d;
            sck_prev_q <= sck_prev_d;
            tail_q     <= tail_d;
            rdata_q    <= rdata_d;
        end
    end

    assign rdata_o = rdata_q;

    // Pin drivers, only the selected group is driven
    genvar gi;
    generate
        for (gi = 0; gi < 2; gi++) begin : g_pins
            always_ff @(posedge ref_clk_i) begin
                if (srst_i) begin
                    sck_o[gi]     <= 1'b0;
                    sck_oe_o[gi]  <= 1'b0;
                    mosi_o[gi]    <= 1'b0;
                    mosi_oe_o[gi] <= 1'b0;
                    miso_o[gi]    <= 1'b0;
                    miso_oe_o[gi] <= 1'b0;
                    ss_n_o[gi]    <= 1'b1;
                    ss_n_oe_o[gi] <= 1'b0;
                end else begin
                    sck_o[gi]     <= sck_lvl_q;
                    sck_oe_o[gi]  <= en & mst & (pinsel_q == 1'(gi));
                    mosi_o[gi]    <= dout_q;
                    mosi_oe_o[gi] <= en & mst & (pinsel_q == 1'(gi));
                    miso_o[gi]    <= dout_q;
                    miso_oe_o[gi] <= sel & (pinsel_q == 1'(gi));
                    ss_n_o[gi]    <= (st_q != ST_XFER) & ~tail_q;
                    ss_n_oe_o[gi] <= autosel_act & (pinsel_q == 1'(gi));
                end
            end
        end
    endgenerate

    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (srst_i);

    chk_clock_half_min: assert property (
        $changed(sck_lvl_q) && st_q == ST_XFER |=> $stable(sck_lvl_q) [*7])
        else $error("Shift clock half period shorter than eight clocks");
    chk_write_collision: assert property (
        wr_i && addr_i == ADDR_DATA && st_q == ST_XFER && !done |=> coll_q && $stable(rxbuf_q))
        else $error("Write during transfer did not flag collision");
    chk_rx_buffer_move: assert property (
        done && !tcf_q && !fault |=> tcf_q && rxbuf_q == $past(sh_d))
        else $error("Received byte not moved to read buffer");
    chk_out_dir_master: assert property (
        |mosi_oe_o |-> $past(ctrl_q[B_MASTER]) && $past(ctrl_q[B_EN]))
        else $error("Data-out line driven outside master mode");
    chk_eight_clocks: assert property (
        $rose(tcf_q) |-> $past(cnt_q) == LAST_EDGE)
        else $error("Transfer completed without sixteen clock edges");
    chk_slave_release: assert property (
        !ctrl_q[B_MASTER] && ss_in |=> miso_oe_o == 2'b00)
        else $error("Deselected slave drives return line");
    chk_auto_select: assert property (
        autosel_act && st_q == ST_XFER |=> ss_n_o == 2'b00 && ss_n_oe_o != 2'b00)
        else $error("Auto select not low during byte");
    chk_mode_fault: assert property (
        fault |=> mfault_q && !ctrl_q[B_MASTER] && st_q == ST_IDLE)
        else $error("Mode fault not flagged");
    chk_disable_quiet: assert property (
        !en |=> (sck_oe_o | mosi_oe_o | miso_oe_o | ss_n_oe_o) == 2'b00)
        else $error("Disabled port drives a pin");
    chk_rdata_idle: assert property (
        !rd_i |=> rdata_o == 8'h00)
        else $error("Read data not zero outside a read");
    chk_status_read: assert property (
        rd_i && addr_i == ADDR_STAT |=> rdata_o[7:3] == $past({tcf_q, coll_q, ovf_q, mfault_q, fdis_q}))
        else $error("Status read does not show the flags");
    chk_done_hold: assert property (
        tcf_q && !(wr_i && addr_i == ADDR_STAT && !wdata_i[B_TCF]) |=> tcf_q)
        else $error("Transfer complete flag lost without a clear");
    chk_coll_hold: assert property (
        coll_q && !(wr_i && addr_i == ADDR_STAT && !wdata_i[B_COLL]) |=> coll_q)
        else $error("Collision flag lost without a clear");
    chk_overrun_keep: assert property (
        done && tcf_q |=> ovf_q && $stable(rxbuf_q))
        else $error("Overrun did not keep the read buffer");
    chk_load_idle: assert property (
        wr_i && addr_i == ADDR_DATA && st_q == ST_IDLE && !stick |=> sh_q == $past(wdata_i))
        else $error("Idle data write not loaded into shifter");
    chk_no_load_busy: assert property (
        wr_i && addr_i == ADDR_DATA && st_q == ST_XFER && !edge_p |=> $stable(sh_q))
        else $error("Data write changed shifter during transfer");
    chk_master_pins: assert property (
        en && mst && !pinsel_q |=> sck_oe_o == 2'b01 && mosi_oe_o == 2'b01)
        else $error("Master does not drive clock and data out");
    chk_group_select: assert property (
        en && mst && pinsel_q |=> sck_oe_o == 2'b10 && mosi_oe_o == 2'b10)
        else $error("Second pin group not driven");
    chk_slave_no_drive: assert property (
        !mst |=> sck_oe_o == 2'b00 && mosi_oe_o == 2'b00)
        else $error("Slave drives clock or data-out line");
    chk_no_fault_dis: assert property (
        en && mst && fdis_q && !mfault_q |=> !mfault_q)
        else $error("Select pin raised a fault while detection is off");
    chk_idle_level: assert property (
        st_q == ST_IDLE |=> sck_lvl_q == $past(ctrl_q[B_IDLE_LEVEL_SELECT]))
        else $error("Shift clock not at idle level");
    chk_count_idle: assert property (
        st_q == ST_IDLE && !edge_p |=> cnt_q == 4'h0)
        else $error("Edge count not cleared while idle");
    chk_deselect_abort: assert property (
        en && !mst && ss_in |=> st_q == ST_IDLE && cnt_q == 4'h0)
        else $error("Deselected slave kept its transfer");
    chk_select_idle: assert property (
        autosel_act && st_q == ST_IDLE && !tail_q |=> ss_n_o == 2'b11)
        else $error("Auto select not high while idle");
    chk_select_gpio: assert property (
        !autosel_act |=> ss_n_oe_o == 2'b00)
        else $error("Select pin driven without auto select");
    chk_msb_shift: assert property (
        samp && !lsb |=> sh_q[7:1] == $past(sh_q[6:0]))
        else $error("MSB first shift wrong");
    chk_lsb_shift: assert property (
        samp && lsb |=> sh_q[6:0] == $past(sh_q[7:1]))
        else $error("LSB first shift wrong");

    cov_master_done: cover property (mst && $rose(tcf_q));
    cov_slave_done:  cover property (!mst && $rose(tcf_q));
    cov_collision:   cover property ($rose(coll_q));
    cov_fault:       cover property ($rose(mfault_q));
    cov_overrun:     cover property ($rose(ovf_q));
endmodule : serial_peripheral_port

//--- testbench/spi_far_slave.sv
`timescale 1ns/1ps
module spi_far_slave (
    // Pins
    input  wire logic       sck_i,
    input  wire logic       ss_n_i,
    input  wire logic       mosi_i,
    output logic            miso_o,
    // Mode and data
    input  wire logic       idle_level_select_i,
    input  wire logic       sample_edge_select_i,
    input  wire logic       lsb_i,
    input  wire logic [7:0] tx_i,
    output logic      [7:0] rx_o
);
    logic [7:0] rx_sh = 8'h00;
    logic       dout  = 1'b0;
    int         n_in  = 0;
    int         n_out = 0;
    function automatic logic pick(input int i);
        return lsb_i ? tx_i[i] : tx_i[7-i];
    endfunction : pick
    // Deselected: inverse of last bit, never stale data
    assign miso_o = ss_n_i ? ~dout : dout;
    always @(negedge ss_n_i) begin
        n_in = 0;
        n_out = sample_edge_select_i ? 0 : 1;
        if (!sample_edge_select_i) dout = pick(0);
    end
    always @(sck_i) begin
        if (!ss_n_i) begin
            if ((sck_i != idle_level_select_i) ^ sample_edge_select_i) begin
                rx_sh = lsb_i ? {mosi_i, rx_sh[7:1]} : {rx_sh[6:0], mosi_i};
                n_in++;
                if (n_in == 8) rx_o = rx_sh;
            end else if (n_out < 8) begin
                dout = pick(n_out);
                n_out++;
            end
        end
    end
endmodule : spi_far_slave

//--- testbench/test_serial_peripheral_port.sv
`timescale 1ns/1ps
module test_serial_peripheral_port;
    import spi_pkg::*;
    typedef struct packed {
        logic [7:0] addr;
        logic       wr;
        logic [7:0] wdata;
        logic [7:0] exp;
    } row_t;
    logic       ref_clk_i, srst_i, wr_i, rd_i, grp, ss_low, p_miso, m_sck, m_mosi;
    logic [7:0] addr_i, wdata_i, rdata_o, ctrl, p_tx, p_rx, d, s_rx;
    logic [1:0] sck_i, sck_o, sck_oe_o, mosi_i, mosi_o, mosi_oe_o;
    logic [1:0] miso_i, miso_o, miso_oe_o, ss_n_i, ss_n_o, ss_n_oe_o, ss_drv;
    int         err_total, n_tests, n_edges;
    time        t_first, t_last;
    row_t       rows [9] = '{'{ADDR_CTRL, 0, 8'h00, 8'h00}, '{ADDR_STAT, 0, 8'h00, 8'h00},
        '{ADDR_DATA, 0, 8'h00, 8'h00}, '{ADDR_AUX, 0, 8'h00, 8'h00},
        '{ADDR_CTRL, 1, 8'h5A, 8'h5A}, '{ADDR_AUX, 1, 8'hFF, 8'h80},
        '{ADDR_STAT, 1, 8'hF8, 8'h08}, '{8'h10, 1, 8'hFF, 8'h00}, '{ADDR_CTRL, 1, 8'h00, 8'h00}};
    assign sck_i  = (sck_oe_o & sck_o) | (~sck_oe_o & {2{m_sck}});
    assign mosi_i = (mosi_oe_o & mosi_o) | (~mosi_oe_o & {2{m_mosi}});
    assign ss_n_i = (ss_n_oe_o & ss_n_o) | (~ss_n_oe_o & ss_drv);
    assign miso_i = grp ? {p_miso, ~p_miso} : {~p_miso, p_miso};
    serial_peripheral_port u_serial_peripheral_port (.ref_clk_i(ref_clk_i), .srst_i(srst_i),
        .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
        .sck_i(sck_i), .sck_o(sck_o), .sck_oe_o(sck_oe_o), .mosi_i(mosi_i), .mosi_o(mosi_o),
        .mosi_oe_o(mosi_oe_o), .miso_i(miso_i), .miso_o(miso_o), .miso_oe_o(miso_oe_o),
        .ss_n_i(ss_n_i), .ss_n_o(ss_n_o), .ss_n_oe_o(ss_n_oe_o));
    spi_far_slave u_spi_far_slave (.sck_i(sck_i[grp]), .ss_n_i(ss_n_i[grp]),
        .mosi_i(mosi_i[grp]), .miso_o(p_miso), .idle_level_select_i(ctrl[B_IDLE_LEVEL_SELECT]), .sample_edge_select_i(ctrl[B_SAMPLE_EDGE_SELECT]),
        .lsb_i(ctrl[B_LSB]), .tx_i(p_tx), .rx_o(p_rx));
    always @(sck_i[grp]) begin
        if (!ss_n_i[grp]) begin
            if (n_edges == 0) t_first = $time;
            t_last = $time;
            n_edges++;
        end
    end
    always @(negedge ss_n_i[grp]) ss_low = 1'b1;
    initial begin
        ref_clk_i = 1'b0;
        forever #12.5 ref_clk_i = ~ref_clk_i;
    end
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        n_tests++;
        if (seen !== exp) begin
            err_total++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check
    task automatic final_report;
        $display("comparisons=%0d mismatches=%0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : final_report
    task automatic wreg(input logic [7:0] a, input logic [7:0] v);
        @(posedge ref_clk_i);
        addr_i  <= a;
        wdata_i <= v;
        wr_i    <= 1'b1;
        @(posedge ref_clk_i);
        wr_i    <= 1'b0;
    endtask : wreg
    task automatic rreg(input logic [7:0] a, output logic [7:0] v);
        @(posedge ref_clk_i);
        addr_i <= a;
        rd_i   <= 1'b1;
        @(posedge ref_clk_i);
        rd_i   <= 1'b0;
        #1 v = rdata_o;
    endtask : rreg
    task automatic wait_bit(input int b);
        logic [7:0] s;
        for (int k = 0; k < 3000; k++) begin
            rreg(ADDR_STAT, s);
            if (s[b] === 1'b1) return;
        end
        check(16'h0000, 16'h0001);
        final_report();
    endtask : wait_bit
    task automatic xfer(input logic [7:0] c, input logic [7:0] tx, input logic [7:0] sb,
                        input logic col);
        int half;
        half = 8 << c[1:0];
        ctrl = c;
        p_tx = sb;
        wreg(ADDR_AUX, {grp, 7'h00});
        wreg(ADDR_STAT, 8'h08);
        wreg(ADDR_CTRL, c);
        n_edges = 0;
        ss_low = 1'b0;
        wreg(ADDR_DATA, tx);
        if (col) wreg(ADDR_DATA, ~tx);
        wait_bit(B_TCF);
        rreg(ADDR_STAT, d);
        check(16'(d), col ? 16'h00C8 : 16'h0088);
        rreg(ADDR_DATA, d);
        check(16'(d), 16'(sb));
        check(16'(p_rx), 16'(tx));
        check(16'(n_edges), 16'h0010);
        check(16'((t_last - t_first) / 25), 16'(15 * half));
        check({14'h0, ss_low, ss_n_i[grp]}, 16'h0003);
        check({14'h0, sck_oe_o}, grp ? 16'h0002 : 16'h0001);
        check({15'h0, sck_i[grp]}, {15'h0, c[B_IDLE_LEVEL_SELECT]});
        $display("done: transfer ctrl=%h", c);
    endtask : xfer
    initial begin
        {srst_i, wr_i, rd_i, addr_i, wdata_i, grp, ctrl, p_tx, ss_low, m_sck, m_mosi} =
            {3'b100, 36'h0};
        ss_drv = 2'b11;
        err_total = 0;
        n_tests = 0;
        n_edges = 0;
        repeat (10) @(posedge ref_clk_i);
        srst_i <= 1'b0;
        foreach (rows[i]) begin
            if (rows[i].wr) wreg(rows[i].addr, rows[i].wdata);
            rreg(rows[i].addr, d);
            check(16'(d), 16'(rows[i].exp));
        end
        $display("done: register table");
        for (int i = 0; i < 8; i++) begin
            grp = i[0];
            xfer({2'b11, i[2], 1'b1, i[1], i[0], i[1:0]}, 8'(8'h1D + i * 29),
                 8'(8'hB4 - i * 37), i == 5);
        end
        p_tx = 8'h66;
        wreg(ADDR_DATA, 8'h99);
        wait_bit(B_OVF);
        rreg(ADDR_DATA, d);
        check(16'(d), 16'(8'(8'hB4 - 7 * 37)));
        rreg(ADDR_STAT, d);
        check(16'(d), 16'h00A8);
        $display("done: overrun");
        grp = 1'b0;
        wreg(ADDR_AUX, 8'h00);
        wreg(ADDR_STAT, 8'h08);
        wreg(ADDR_CTRL, 8'h50);
        ss_drv <= 2'b00;
        repeat (20) @(posedge ref_clk_i);
        rreg(ADDR_CTRL, d);
        check(16'(d), 16'h0050);
        check({14'h0, ss_n_oe_o}, 16'h0000);
        wreg(ADDR_STAT, 8'h00);
        repeat (20) @(posedge ref_clk_i);
        rreg(ADDR_CTRL, d);
        check(16'(d), 16'h0040);
        rreg(ADDR_STAT, d);
        check(16'(d), 16'h0010);
        ss_drv <= 2'b11;
        $display("done: mode fault");
        wreg(ADDR_STAT, 8'h08);
        wreg(ADDR_CTRL, 8'h10);
        wreg(ADDR_DATA, 8'h5A);
        repeat (300) @(posedge ref_clk_i);
        check({14'h0, sck_oe_o}, 16'h0000);
        rreg(ADDR_STAT, d);
        check(16'(d), 16'h0008);
        $display("done: disabled port");
        wreg(ADDR_CTRL, 8'h40);
        wreg(ADDR_DATA, 8'hC3);
        ss_drv <= 2'b10;
        for (int b = 7; b >= 0; b--) begin
            m_mosi <= 1'(8'h96 >> b);
            repeat (4) @(posedge ref_clk_i);
            s_rx[b] = miso_o[0];
            m_sck <= 1'b1;
            repeat (4) @(posedge ref_clk_i);
            m_sck <= 1'b0;
        end
        repeat (4) @(posedge ref_clk_i);
        check({14'h0, miso_oe_o}, 16'h0001);
        ss_drv <= 2'b11;
        rreg(ADDR_DATA, d);
        check(16'(d), 16'h0096);
        check(16'(s_rx), 16'h00C3);
        rreg(ADDR_STAT, d);
        check(16'(d), 16'h0088);
        check({14'h0, miso_oe_o}, 16'h0000);
        $display("done: slave transfer");
        srst_i <= 1'b1;
        repeat (3) @(posedge ref_clk_i);
        srst_i <= 1'b0;
        rreg(ADDR_CTRL, d);
        check(16'(d), 16'(CTRL_RST));
        rreg(ADDR_STAT, d);
        check(16'(d), 16'(STAT_RST));
        $display("done: reset in mid-run");
        final_report();
    end
endmodule : test_serial_peripheral_port
